// ### pos_regs.svh
// register offsets, field positions, reset values and timing figures of the power-off sequencer
// assumes: included by bare name from the design files of the block
`ifndef POS_REGS_SVH
`define POS_REGS_SVH

`define POS_ADDR_W 8
`define POS_OFF_CONFIG 8'h00
`define POS_OFF_MASK 8'h04
`define POS_OFF_HOLD 8'h08
`define POS_OFF_STATUS 8'h0C

`define POS_CFG_TASK_DIS_BIT 15
`define POS_CFG_DELAY_MSB 7
`define POS_CFG_RESET 16'h8000
`define POS_MASK_KEY 16'hA5A5
`define POS_MASK_RESET 16'h0000
`define POS_HOLD_IOM_BIT 0
`define POS_HOLD_RETAIN_BIT 1

`define POS_RESP_OKAY 2'b00
`define POS_RESP_SLVERR 2'b10

`define POS_CLK_PERIOD_NS 20
`define POS_NS_PER_MS 1000000
`define POS_HOLDUP_MS 10
`define POS_DELAY_MAX_MS 10
`define POS_REDUCED_HOLDUP_MS 1

`endif

// ### pos_pkg.sv
// types shared by the power-off sequencer files
// assumes: compiled before every module of the block
package pos_pkg;

   typedef enum logic [4:0] {
      POS_IDLE = 5'b00001,
      POS_DELAY = 5'b00010,
      POS_DRAIN = 5'b00100,
      POS_TASK = 5'b01000,
      POS_RESET = 5'b10000
   } pos_state_e;

   typedef logic [3:0] pos_ms_t;

endpackage : pos_pkg

// ### pos_sync3.sv
// three-stage synchroniser for a level arriving from outside the clock domain
// assumes: one clock; the output only changes once stages two and three agree
`timescale 1ns/10ps
`default_nettype none

module pos_sync3 (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic async_in,
   output logic level_out
);

   logic stage1;
   logic stage2;
   logic stage3;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level_out <= 1'b0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
         if (stage2 == stage3) begin
            level_out <= stage3;
         end
      end
   end

endmodule : pos_sync3
`default_nettype wire

// ### pos_ms_tick.sv
// millisecond enable pulse, restartable so that counts align to the detection instant
// assumes: one clock; cycles per millisecond is at least two
`timescale 1ns/10ps
`default_nettype none

module pos_ms_tick #(
   parameter int CYC_PER_MS = 50000
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic restart_in,
   output logic tick_out
);

   localparam int CW = $clog2(CYC_PER_MS);
   localparam logic [CW-1:0] LAST = CW'(CYC_PER_MS - 1);

   logic [CW-1:0] count;
   wire at_last = (count == LAST);

   // refused at elaboration: a one-cycle millisecond leaves no room for the restart
   if (CYC_PER_MS < 2) begin : g_cpm_check
      $error("pos_ms_tick: CYC_PER_MS must be at least 2");
   end

   always_ff @(posedge clk_in) begin
      if (reset_in || restart_in) begin
         count <= '0;
         tick_out <= 1'b0;
      end else begin
         count <= at_last ? '0 : count + 1'b1;
         tick_out <= at_last;
      end
   end

endmodule : pos_ms_tick
`default_nettype wire

// ### pos_sequencer.sv
// power-off sequencer: power-fail confirmation, power-off task, protected region, cpu reset
// assumes: one 50 MHz clock; sequencer signals are on this clock; power-fail and supply
// variant come from pins; registers are reached over an AXI4-Lite slave port
//
// Design decisions made here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`default_nettype none
`include "pos_regs.svh"

module pos_sequencer #(
   parameter int CYC_PER_MS = `POS_NS_PER_MS / `POS_CLK_PERIOD_NS
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic power_fail_in,
   input wire logic reduced_supply_in,
   input wire logic run_mode_in,
   input wire logic instr_busy_in,
   input wire logic interrupt_disable_instr_exec_in,
   input wire logic interrupt_disable_instr_done_in,
   input wire logic interrupt_enable_instr_done_in,
   input wire logic program_end_in,
   input wire logic task_done_in,
   output logic halt_request_out,
   output logic task_run_out,
   output logic task_abort_out,
   output logic instr_abort_out,
   output logic cpu_reset_out,
   output logic outputs_off_out,
   input wire logic [`POS_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [`POS_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   localparam pos_pkg::pos_ms_t HOLDUP_MS = 4'(`POS_HOLDUP_MS);
   localparam pos_pkg::pos_ms_t DELAY_MAX_MS = 4'(`POS_DELAY_MAX_MS);
   localparam pos_pkg::pos_ms_t REDUCED_MS = 4'(`POS_REDUCED_HOLDUP_MS);

   if (CYC_PER_MS < 2) begin : g_cpm_check
      $error("pos_sequencer: CYC_PER_MS must be at least 2");
   end

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (reset_in);

   // registers
   logic [15:0] config_word;
   logic [15:0] power_fail_mask_word;
   logic io_memory_hold_bit;
   logic hold_retain_at_startup;
   // sequencing state
   pos_pkg::pos_state_e state;
   pos_pkg::pos_state_e next_state;
   pos_pkg::pos_ms_t ms_count;
   logic in_region;
   logic skip_region;
   // synchronised pins
   logic power_fail;
   logic reduced_supply;

   pos_sync3 u_pf_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .async_in(power_fail_in),
      .level_out(power_fail)
   );

   pos_sync3 u_variant_sync (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .async_in(reduced_supply_in),
      .level_out(reduced_supply)
   );

   wire detect = (state == pos_pkg::POS_IDLE) && power_fail && run_mode_in;
   logic ms_tick;

   pos_ms_tick #(
      .CYC_PER_MS(CYC_PER_MS)
   ) u_tick (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .restart_in(detect),
      .tick_out(ms_tick)
   );

   // effective settings; the reduced variant forces zero delay and no task
   wire [7:0] cfg_delay = config_word[`POS_CFG_DELAY_MSB:0];
   wire cfg_task_dis = config_word[`POS_CFG_TASK_DIS_BIT];
   wire task_en = !reduced_supply && !cfg_task_dis;
   wire [3:0] delay_ms = reduced_supply ? 4'h0 :
      ((cfg_delay > 8'(DELAY_MAX_MS)) ? DELAY_MAX_MS : cfg_delay[3:0]);
   wire [3:0] window_ms = reduced_supply ? REDUCED_MS : HOLDUP_MS;
   wire delay_done = (ms_count >= delay_ms);
   wire window_over = (ms_count >= window_ms);

   wire key_set = (power_fail_mask_word == `POS_MASK_KEY);
   wire protect_active = key_set && !task_en && in_region && !skip_region;
   wire drain_done = !instr_busy_in && !protect_active;
   wire keep_mask = io_memory_hold_bit && hold_retain_at_startup;

   always_comb begin
      next_state = state;
      case (state)
         pos_pkg::POS_IDLE: begin
            if (detect) begin
               next_state = pos_pkg::POS_DELAY;
            end
         end
         pos_pkg::POS_DELAY: begin
            // a supply that recovers before confirmation does not stop the processor
            if (!power_fail) begin
               next_state = pos_pkg::POS_IDLE;
            end else if (delay_done) begin
               next_state = pos_pkg::POS_DRAIN;
            end
         end
         pos_pkg::POS_DRAIN: begin
            if (window_over) begin
               next_state = pos_pkg::POS_RESET;
            end else if (drain_done) begin
               next_state = task_en ? pos_pkg::POS_TASK : pos_pkg::POS_RESET;
            end
         end
         pos_pkg::POS_TASK: begin
            if (task_done_in || window_over) begin
               next_state = pos_pkg::POS_RESET;
            end
         end
         pos_pkg::POS_RESET: begin
            next_state = pos_pkg::POS_RESET;
         end
         default: begin
            next_state = pos_pkg::POS_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state <= pos_pkg::POS_IDLE;
         ms_count <= 4'h0;
      end else begin
         state <= next_state;
         if (detect) begin
            ms_count <= 4'h0;
         end else if (ms_tick && ms_count != 4'hF) begin
            ms_count <= ms_count + 4'h1;
         end
      end
   end

   // protected region tracking
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         in_region <= 1'b0;
         skip_region <= 1'b0;
      end else begin
         if (interrupt_enable_instr_done_in || program_end_in) begin
            in_region <= 1'b0;
         end else if (interrupt_disable_instr_done_in) begin
            in_region <= 1'b1;
         end
         if (detect && interrupt_disable_instr_exec_in) begin
            skip_region <= 1'b1;
         end else if (state == pos_pkg::POS_IDLE) begin
            skip_region <= 1'b0;
         end
      end
   end

   // outputs to the processor, all registered; halt, task run and reset from the next state, the two aborts from the current state
   wire going_reset = (next_state == pos_pkg::POS_RESET);

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         halt_request_out <= 1'b0;
         task_run_out <= 1'b0;
         task_abort_out <= 1'b0;
         instr_abort_out <= 1'b0;
         cpu_reset_out <= 1'b0;
         outputs_off_out <= 1'b0;
      end else begin
         halt_request_out <= (next_state != pos_pkg::POS_IDLE) &&
            (next_state != pos_pkg::POS_DELAY);
         task_run_out <= (next_state == pos_pkg::POS_TASK);
         task_abort_out <= (state == pos_pkg::POS_TASK) && window_over && !task_done_in;
         instr_abort_out <= (state == pos_pkg::POS_DRAIN) && window_over && instr_busy_in;
         cpu_reset_out <= going_reset;
         outputs_off_out <= going_reset;
      end
   end

   // AXI4-Lite slave; write takes address and data in either order
   logic aw_full;
   logic w_full;
   logic [`POS_ADDR_W-1:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take = s_axi_wvalid && s_axi_wready;
   wire do_write = aw_full && w_full && !s_axi_bvalid;
   wire next_aw_full = (aw_full || aw_take) && !do_write;
   wire next_w_full = (w_full || w_take) && !do_write;
   wire next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
   wire ar_take = s_axi_arvalid && s_axi_arready;
   wire next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);

   wire wr_cfg = do_write && (aw_addr == `POS_OFF_CONFIG);
   wire wr_mask = do_write && (aw_addr == `POS_OFF_MASK);
   wire wr_hold = do_write && (aw_addr == `POS_OFF_HOLD);
   wire wr_hit = wr_cfg || wr_mask || wr_hold || (aw_addr == `POS_OFF_STATUS);
   wire [15:0] lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
   wire [15:0] cfg_merged = (config_word & ~lane_mask) | (w_data[15:0] & lane_mask);
   wire [15:0] mask_merged = (power_fail_mask_word & ~lane_mask) | (w_data[15:0] & lane_mask);

   wire [31:0] status_word = {20'h0_0000, ms_count, protect_active, in_region,
      reduced_supply, power_fail, 3'h0, state == pos_pkg::POS_RESET};
   wire rd_hit = (s_axi_araddr == `POS_OFF_CONFIG) || (s_axi_araddr == `POS_OFF_MASK) ||
      (s_axi_araddr == `POS_OFF_HOLD) || (s_axi_araddr == `POS_OFF_STATUS);
   wire [31:0] rd_word =
      (s_axi_araddr == `POS_OFF_CONFIG) ? {16'h0000, config_word} :
      (s_axi_araddr == `POS_OFF_MASK) ? {16'h0000, power_fail_mask_word} :
      (s_axi_araddr == `POS_OFF_HOLD) ? {30'h0000_0000, hold_retain_at_startup,
         io_memory_hold_bit} :
      (s_axi_araddr == `POS_OFF_STATUS) ? status_word : 32'h0000_0000;

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         aw_addr <= '0;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `POS_RESP_OKAY;
      end else begin
         aw_full <= next_aw_full;
         w_full <= next_w_full;
         if (aw_take) begin
            aw_addr <= s_axi_awaddr;
         end
         if (w_take) begin
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         s_axi_awready <= !next_aw_full && !next_bvalid;
         s_axi_wready <= !next_w_full && !next_bvalid;
         s_axi_bvalid <= next_bvalid;
         if (do_write) begin
            s_axi_bresp <= wr_hit ? `POS_RESP_OKAY : `POS_RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `POS_RESP_OKAY;
      end else begin
         s_axi_arready <= !next_rvalid;
         s_axi_rvalid <= next_rvalid;
         if (ar_take) begin
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? `POS_RESP_OKAY : `POS_RESP_SLVERR;
         end
      end
   end

   // register storage; power-off clearing of the mask word wins over a bus write
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         config_word <= `POS_CFG_RESET;
         power_fail_mask_word <= `POS_MASK_RESET;
         io_memory_hold_bit <= 1'b0;
         hold_retain_at_startup <= 1'b0;
      end else begin
         if (wr_cfg) begin
            config_word <= cfg_merged;
         end
         if (going_reset && state != pos_pkg::POS_RESET && !keep_mask) begin
            power_fail_mask_word <= `POS_MASK_RESET;
         end else if (wr_mask) begin
            power_fail_mask_word <= mask_merged;
         end
         if (wr_hold && w_strb[0]) begin
            io_memory_hold_bit <= w_data[`POS_HOLD_IOM_BIT];
            hold_retain_at_startup <= w_data[`POS_HOLD_RETAIN_BIT];
         end
      end
   end

   // checks
   confirm_after_delay_a: assert property (
      $rose(halt_request_out) |-> $past(ms_count) >= $past(delay_ms))
      else $error("confirmation before the programmed delay");
   stop_by_window_a: assert property (
      (state == pos_pkg::POS_DRAIN || state == pos_pkg::POS_TASK) && window_over
      |=> cpu_reset_out && outputs_off_out)
      else $error("processor not stopped at window end");
   reset_no_task_a: assert property (
      state == pos_pkg::POS_DRAIN && drain_done && !window_over && !task_en
      |=> cpu_reset_out && !task_run_out)
      else $error("reset not asserted right after confirmation");
   reset_after_task_a: assert property (
      state == pos_pkg::POS_TASK && !task_done_in && !window_over |=> !cpu_reset_out)
      else $error("reset asserted while power-off task runs");
   task_cut_off_a: assert property (
      state == pos_pkg::POS_TASK && window_over && !task_done_in
      |=> task_abort_out && !task_run_out ##1 !task_abort_out)
      else $error("power-off task not terminated at window end");
   instr_abort_a: assert property (
      state == pos_pkg::POS_DRAIN && window_over && instr_busy_in |=> instr_abort_out)
      else $error("instruction not aborted at budget end");
   region_held_a: assert property (
      state == pos_pkg::POS_DRAIN && protect_active && !window_over
      |=> !cpu_reset_out && halt_request_out)
      else $error("reset taken inside protected region");
   mask_cleared_a: assert property (
      $rose(cpu_reset_out) && !keep_mask |-> power_fail_mask_word == `POS_MASK_RESET)
      else $error("mask word kept at power-off");
   task_default_off_a: assert property (
      $past(reset_in) |-> cfg_task_dis)
      else $error("power-off task not disabled after reset");
   reduced_window_a: assert property (
      reduced_supply |-> window_ms == REDUCED_MS && delay_ms == 4'h0 && !task_en)
      else $error("reduced variant settings not forced");

endmodule : pos_sequencer
`default_nettype wire

// ### pos_psu_model.sv
// supply model: raises the power-fail level once drop_in has been high at DETECT_CYC+1 successive clock edges
// assumes: drop_in is driven by the bench on the controller clock
`timescale 1ns/10ps
`default_nettype none

module pos_psu_model #(
   parameter int DETECT_CYC = 3
) (
   input wire logic clk_in,
   input wire logic drop_in,
   output logic power_fail_out
);
   int low_cyc = 0;

   initial power_fail_out = 1'h0;

   // a dip shorter than the detection time is ridden out; recovery clears at once
   always @(posedge clk_in) begin
      low_cyc <= drop_in ? low_cyc + 1 : 0;
      power_fail_out <= drop_in && (low_cyc >= DETECT_CYC);
   end
endmodule : pos_psu_model

`default_nettype wire

// ### tb.sv
// self-checking bench of the power-off sequencer: timing table, region, hold, supply variant
// assumes: pos_regs.svh, pos_pkg, the design files and the supply model compile first
`timescale 1ns/10ps
`default_nettype none
`include "pos_regs.svh"

module tb;
   localparam int CPM = 20;
   typedef struct {
      logic [15:0] cfg;
      logic [15:0] mask;
      logic region;
      logic done;
      int lo;
      int hi;
      logic tsk;
      logic [1:0] ab;
   } pos_row_s;
   // counts run from the supply indication rising; sync and decision add a few cycles
   pos_row_s rows [7] = '{
      '{16'h8000, 16'h0000, 1'h0, 1'h0, 0, 12, 1'h0, 2'h0},
      '{16'h8005, 16'h0000, 1'h0, 1'h0, 100, 112, 1'h0, 2'h0},
      '{16'h800A, 16'h0000, 1'h0, 1'h0, 195, 214, 1'h0, 2'h0},
      '{16'h800F, 16'h0000, 1'h0, 1'h0, 195, 214, 1'h0, 2'h0},
      '{16'h0003, 16'hA5A5, 1'h1, 1'h1, 60, 78, 1'h1, 2'h0},
      '{16'h0002, 16'h0000, 1'h0, 1'h0, 195, 214, 1'h1, 2'h2},
      '{16'h8000, 16'h1234, 1'h1, 1'h0, 0, 12, 1'h0, 2'h0}
   };
   logic clk_in = 1'h0, reset_in = 1'h1, drop = 1'h0, reduced = 1'h0, run_mode = 1'h1;
   logic busy = 1'h0, dis_exec = 1'h0, dis_done = 1'h0, en_done = 1'h0, prog_end = 1'h0;
   logic task_done = 1'h0, power_fail, halt, task_run, task_abort, instr_abort;
   logic cpu_reset, outs_off, awready, wready, bvalid, arready, rvalid;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, got;
   logic [1:0] bresp, rresp;
   int n_fail = 0, samples_checked = 0, cyc = 0;

   pos_psu_model #(.DETECT_CYC(3)) PSU (.clk_in(clk_in), .drop_in(drop),
      .power_fail_out(power_fail));

   pos_sequencer #(.CYC_PER_MS(CPM)) DUT (
      .clk_in(clk_in), .reset_in(reset_in), .power_fail_in(power_fail),
      .reduced_supply_in(reduced), .run_mode_in(run_mode), .instr_busy_in(busy),
      .interrupt_disable_instr_exec_in(dis_exec), .interrupt_disable_instr_done_in(dis_done),
      .interrupt_enable_instr_done_in(en_done), .program_end_in(prog_end),
      .task_done_in(task_done), .halt_request_out(halt), .task_run_out(task_run),
      .task_abort_out(task_abort), .instr_abort_out(instr_abort), .cpu_reset_out(cpu_reset),
      .outputs_off_out(outs_off), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
   );

   initial begin
      forever #10 clk_in = ~clk_in;
   end

   task automatic results;
      if (n_fail == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results

   // longest path is well under this; a hang lands in the report
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         results();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      // no wait limit of its own: a slave that never answers runs into the bench timeout
      do begin
         @(posedge clk_in);
         if (awvalid && awready === 1'h1) awvalid <= 1'h0;
         if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      chk("bresp", {30'h0, er}, {30'h0, bresp});
      @(posedge clk_in);
   endtask : axw

   task automatic axr(input logic [7:0] a, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge clk_in);
         if (arvalid && arready === 1'h1) arvalid <= 1'h0;
         got = rdata;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      chk("rresp", {30'h0, er}, {30'h0, rresp});
      @(posedge clk_in);
   endtask : axr

   // four cycles of reset also flush the input synchronisers
   task automatic setup(input logic [15:0] cfg, input logic [15:0] mask, input logic [1:0] hold);
      reset_in <= 1'h1;
      drop <= 1'h0;
      busy <= 1'h0;
      dis_exec <= 1'h0;
      task_done <= 1'h0;
      repeat (4) @(posedge clk_in);
      reset_in <= 1'h0;
      @(posedge clk_in);
      axw(`POS_OFF_CONFIG, {16'h0000, cfg}, `POS_RESP_OKAY);
      axw(`POS_OFF_MASK, {16'h0000, mask}, `POS_RESP_OKAY);
      axw(`POS_OFF_HOLD, {30'h0, hold}, `POS_RESP_OKAY);
   endtask : setup

   task automatic act(input int k, input int w);
      repeat (k) @(posedge clk_in);
      case (w)
         0: busy <= 1'h0;
         1: en_done <= 1'h1;
         2: prog_end <= 1'h1;
         default: begin
            dis_exec <= 1'h0;
            dis_done <= 1'h1;
         end
      endcase
      @(posedge clk_in);
      en_done <= 1'h0;
      prog_end <= 1'h0;
      dis_done <= 1'h0;
   endtask : act

   // drops the supply and times the processor reset from the indication rising
   task automatic watch(input int lo, input int hi, input logic dn, input logic tsk,
      input logic [1:0] ab);
      int n;
      logic saw_t;
      logic [1:0] saw_a;
      n = 0;
      saw_t = 1'h0;
      saw_a = 2'h0;
      drop <= 1'h1;
      @(posedge clk_in);
      while (power_fail !== 1'h1) @(posedge clk_in);
      while (cpu_reset !== 1'h1 && n < 400) begin
         @(posedge clk_in);
         n++;
         saw_t = saw_t | (task_run === 1'h1);
         saw_a = saw_a | {task_abort === 1'h1, instr_abort === 1'h1};
         task_done <= dn & (task_run === 1'h1);
         chk("outputs_off", {31'h0, cpu_reset}, {31'h0, outs_off});
      end
      @(posedge clk_in);
      saw_a = saw_a | {task_abort === 1'h1, instr_abort === 1'h1};
      chk("halt_request", 32'h1, {31'h0, halt});
      chk("reset_cycle_in_range", 32'h1, {31'h0, (n >= lo && n <= hi)});
      chk("task_ran", {31'h0, tsk}, {31'h0, saw_t});
      chk("aborts", {30'h0, ab}, {30'h0, saw_a});
   endtask : watch

   initial begin
      setup(`POS_CFG_RESET, 16'h0000, 2'h0);
      axr(`POS_OFF_CONFIG, `POS_RESP_OKAY);
      chk("config_reset", 32'h0000_8000, got);
      axr(8'h10, `POS_RESP_SLVERR);
      chk("unmapped_rdata", 32'h0000_0000, got);
      axw(8'h14, 32'h0000_1234, `POS_RESP_SLVERR);
      for (int i = 0; i < 7; i++) begin
         setup(rows[i].cfg, rows[i].mask, 2'h0);
         if (rows[i].region) act(0, 3);
         watch(rows[i].lo, rows[i].hi, rows[i].done, rows[i].tsk, rows[i].ab);
         axr(`POS_OFF_MASK, `POS_RESP_OKAY);
         chk("mask_cleared", 32'h0000_0000, got);
      end
      // open region is finished first, closed by the enable instruction or program end
      for (int k = 1; k < 3; k++) begin
         setup(16'h8000, `POS_MASK_KEY, 2'h0);
         act(0, 3);
         fork
            watch(50, 70, 1'h0, 1'h0, 2'h0);
            act(60, k);
         join
      end
      setup(16'h8000, 16'h0000, 2'h0);
      busy <= 1'h1;
      fork
         watch(50, 70, 1'h0, 1'h0, 2'h0);
         act(60, 0);
      join
      setup(16'h8000, 16'h0000, 2'h0);
      busy <= 1'h1;
      watch(195, 214, 1'h0, 1'h0, 2'h1);
      setup(16'h8002, `POS_MASK_KEY, 2'h0);
      dis_exec <= 1'h1;
      fork
         watch(40, 54, 1'h0, 1'h0, 2'h0);
         act(12, 3);
      join
      setup(16'h8000, `POS_MASK_KEY, 2'h3);
      watch(0, 12, 1'h0, 1'h0, 2'h0);
      axr(`POS_OFF_MASK, `POS_RESP_OKAY);
      chk("mask_held", 32'h0000_A5A5, got);
      axr(`POS_OFF_STATUS, `POS_RESP_OKAY);
      chk("status_reset_pf", 32'h0000_0011, got & 32'h0000_0031);
      // a busy instruction holds the stop until the 1 ms window; the 10 ms delay is ignored
      reduced <= 1'h1;
      setup(16'h800A, 16'h0000, 2'h0);
      busy <= 1'h1;
      watch(20, 34, 1'h0, 1'h0, 2'h1);
      reduced <= 1'h0;
      // no stop when not running, nor after a dip that recovers before confirmation
      for (int j = 0; j < 2; j++) begin
         setup(16'h8005, 16'h0000, 2'h0);
         run_mode <= j[0];
         drop <= 1'h1;
         repeat (j == 0 ? 250 : 40) @(posedge clk_in);
         drop <= 1'h0;
         repeat (250) @(posedge clk_in);
         chk("no_stop", 32'h0, {31'h0, cpu_reset | halt});
         run_mode <= 1'h1;
      end
      results();
   end
endmodule : tb

`default_nettype wire
